// file: src/axis_seq_pkg.sv
// Package with timing constants, modes and carrier types for the sequencer
package axis_seq_pkg;
    // Clock rate
    localparam int CLK_PERIOD_PS = 5000;
    // Latency figures in microseconds, nominal values
    localparam int T_ZERO_MIN_US = 5500;
    localparam int T_INDEP_MIN_US = 15000;
    localparam int T_INTERP_MIN_US = 61000;
    localparam int T_ZERO_MAX_US = 14000;
    localparam int T_INDEP_MAX_US = 58000;
    localparam int T_INTERP_MAX_US = 94000;
    localparam int T_OTHER_AXIS_US = 99000;
    localparam int T_PERIPH_US = 3000;
    localparam int T_SPEED_POINT_US = 10000;
    // Cycle counts derived from the figures (exact products of whole cycles per microsecond, no rounding)
    localparam int CYC_PER_US = 1000000 / CLK_PERIOD_PS;
    localparam int C_ZERO_MIN = T_ZERO_MIN_US * CYC_PER_US;
    localparam int C_INDEP_MIN = T_INDEP_MIN_US * CYC_PER_US;
    localparam int C_INTERP_MIN = T_INTERP_MIN_US * CYC_PER_US;
    localparam int C_ZERO_MAX = T_ZERO_MAX_US * CYC_PER_US;
    localparam int C_INDEP_MAX = T_INDEP_MAX_US * CYC_PER_US;
    localparam int C_INTERP_MAX = T_INTERP_MAX_US * CYC_PER_US;
    localparam int C_OTHER_AXIS = T_OTHER_AXIS_US * CYC_PER_US;
    localparam int C_PERIPH = T_PERIPH_US * CYC_PER_US;
    localparam int C_SPEED_POINT = T_SPEED_POINT_US * CYC_PER_US;
    // Error code for start while busy
    localparam logic [7:0] ERR_START_BUSY = 8'h49;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam int CNT_W = 32;

    // Operation kinds of a start request
    typedef enum logic [1:0] {
        OP_ZERO = 2'h0,
        OP_INDEP = 2'h1,
        OP_INTERP = 2'h2
    } op_kind_t;

    // Start request of one axis
    typedef struct packed {
        logic start;
        op_kind_t op;
        logic prev_cancelled;
        logic [4:0] speed_points;
    } start_req_t;

    // Status of one axis
    typedef struct packed {
        logic busy;
        logic pulse_enable;
        logic err_valid;
        logic [7:0] err_code;
    } axis_status_t;
endpackage

// file: src/axis_start_timer.sv
// One axis start-processing timer with busy and pulse enable
`timescale 1ns/10ps
module axis_start_timer #(
    parameter int C_ZERO_MIN_P = axis_seq_pkg::C_ZERO_MIN,
    parameter int C_INDEP_MIN_P = axis_seq_pkg::C_INDEP_MIN,
    parameter int C_INTERP_MIN_P = axis_seq_pkg::C_INTERP_MIN,
    parameter int C_ZERO_MAX_P = axis_seq_pkg::C_ZERO_MAX,
    parameter int C_INDEP_MAX_P = axis_seq_pkg::C_INDEP_MAX,
    parameter int C_INTERP_MAX_P = axis_seq_pkg::C_INTERP_MAX,
    parameter int C_OTHER_P = axis_seq_pkg::C_OTHER_AXIS,
    parameter int C_PERIPH_P = axis_seq_pkg::C_PERIPH,
    parameter int C_POINT_P = axis_seq_pkg::C_SPEED_POINT
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Request and conditions
    input wire axis_seq_pkg::start_req_t req,
    input wire logic other_busy,
    input wire logic host_buffer_transfer,
    input wire logic periph_active,
    input wire logic done,
    // Status
    output axis_seq_pkg::axis_status_t status
);
    import axis_seq_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_RUN = 4'b1000
    } state_t;

    state_t state;
    state_t next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] base_cycles;
    logic [CNT_W-1:0] extra_cycles;
    logic start_seen;
    axis_status_t next_status;

    // Base latency from kind of operation and its history
    wire logic [CNT_W-1:0] min_sel = (req.op == OP_ZERO) ? C_ZERO_MIN_P[CNT_W-1:0]
        : (req.op == OP_INDEP) ? C_INDEP_MIN_P[CNT_W-1:0]
        : C_INTERP_MIN_P[CNT_W-1:0]; // RULE8
    wire logic [CNT_W-1:0] max_sel = (req.op == OP_ZERO) ? C_ZERO_MAX_P[CNT_W-1:0]
        : (req.op == OP_INDEP) ? C_INDEP_MAX_P[CNT_W-1:0]
        : C_INTERP_MAX_P[CNT_W-1:0]; // RULE9
    wire logic [CNT_W-1:0] kind_cycles = req.prev_cancelled ? max_sel
        : min_sel;
    wire logic [CNT_W-1:0] point_cycles = CNT_W'(req.speed_points)
        * C_POINT_P[CNT_W-1:0]; // RULE7
    wire logic [CNT_W-1:0] other_cycles = other_busy ? C_OTHER_P[CNT_W-1:0]
        : '0; // RULE5
    wire logic [CNT_W-1:0] periph_cycles = periph_active
        ? C_PERIPH_P[CNT_W-1:0] : '0; // RULE6
    wire logic start_rise = req.start && !start_seen;
    wire logic expired = (count == '0);

    // State selection; buffer transfers freeze the count
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (start_rise) next_state = ST_LOAD;
            ST_LOAD: next_state = ST_WAIT;
            ST_WAIT: if (expired && !host_buffer_transfer) begin
                next_state = ST_RUN; // RULE2 RULE4
            end
            ST_RUN: if (done) next_state = ST_IDLE;
        endcase
    end

    // Status outputs as registered values
    always_comb begin
        next_status = status;
        next_status.err_valid = 1'b0;
        next_status.busy = (next_state == ST_RUN); // RULE2
        next_status.pulse_enable = (next_state == ST_RUN)
            && (state == ST_RUN); // RULE3
        if (start_rise && state == ST_RUN) begin
            next_status.err_valid = 1'b1; // RULE10
            next_status.err_code = ERR_START_BUSY;
        end
    end

    // State, counter and status registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= ST_IDLE;
            count <= '0;
            base_cycles <= '0;
            extra_cycles <= '0;
            start_seen <= 1'b0;
            status <= '{busy: 1'b0, pulse_enable: 1'b0, err_valid: 1'b0,
                err_code: ERR_NONE};
        end else begin
            state <= next_state;
            start_seen <= req.start;
            status <= next_status;
            if (state == ST_IDLE && start_rise) begin
                base_cycles <= kind_cycles + point_cycles;
                extra_cycles <= other_cycles + periph_cycles;
            end
            if (state == ST_LOAD) begin
                count <= base_cycles + extra_cycles; // RULE11
            end else if (state == ST_WAIT && !expired
                && !host_buffer_transfer) begin
                count <= count - 1'b1; // RULE4 RULE11
            end
        end
    end
endmodule

// file: src/axis_start_busy_sequencer.sv
// Two-axis start-to-busy sequencer with battery-low signalling
// Behaviour
// [RULE1] Low battery lights lamp and flags controller
// [RULE2] Busy rises after start latency elapses
// [RULE3] Feed pulses only after busy and latency
// [RULE4] Buffer transfers hold off start processing
// [RULE5] Other axis running adds under 100 ms
// [RULE6] Peripheral intervention adds a few ms
// [RULE7] Each speed-change point adds about 10 ms
// [RULE8] Minimum latency after completed operations
// [RULE9] Maximum latency after cancelled operations
// [RULE10] Start while busy rejected with error
// [RULE11] Per-axis timers on system clock
`timescale 1ns/10ps
module axis_start_busy_sequencer #(
    // Latency counts in clock cycles; short values shorten simulation
    parameter int C_ZERO_MIN_P = axis_seq_pkg::C_ZERO_MIN,
    parameter int C_INDEP_MIN_P = axis_seq_pkg::C_INDEP_MIN,
    parameter int C_INTERP_MIN_P = axis_seq_pkg::C_INTERP_MIN,
    parameter int C_ZERO_MAX_P = axis_seq_pkg::C_ZERO_MAX,
    parameter int C_INDEP_MAX_P = axis_seq_pkg::C_INDEP_MAX,
    parameter int C_INTERP_MAX_P = axis_seq_pkg::C_INTERP_MAX,
    parameter int C_OTHER_P = axis_seq_pkg::C_OTHER_AXIS,
    parameter int C_PERIPH_P = axis_seq_pkg::C_PERIPH,
    parameter int C_POINT_P = axis_seq_pkg::C_SPEED_POINT
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Start requests per axis
    input wire axis_seq_pkg::start_req_t req_one,
    input wire axis_seq_pkg::start_req_t req_two,
    // Operation ends per axis
    input wire logic done_one,
    input wire logic done_two,
    // Contention sources
    input wire logic host_buffer_transfer,
    input wire logic periph_active,
    // Battery monitor
    input wire logic battery_low,
    // Axis status
    output logic busy_axis_one,
    output logic busy_axis_two,
    output logic pulse_enable_one,
    output logic pulse_enable_two,
    output logic err_valid_one,
    output logic err_valid_two,
    output logic [7:0] err_code_one,
    output logic [7:0] err_code_two,
    // Battery indications
    output logic battery_led,
    output logic battery_error
);
    import axis_seq_pkg::*;

    axis_status_t stat_one;
    axis_status_t stat_two;

    // Axis one timer; the other axis counts while busy
    axis_start_timer #(
        .C_ZERO_MIN_P(C_ZERO_MIN_P),
        .C_INDEP_MIN_P(C_INDEP_MIN_P),
        .C_INTERP_MIN_P(C_INTERP_MIN_P),
        .C_ZERO_MAX_P(C_ZERO_MAX_P),
        .C_INDEP_MAX_P(C_INDEP_MAX_P),
        .C_INTERP_MAX_P(C_INTERP_MAX_P),
        .C_OTHER_P(C_OTHER_P),
        .C_PERIPH_P(C_PERIPH_P),
        .C_POINT_P(C_POINT_P)
    ) timer_one (
        .mclk(mclk),
        .reset(reset),
        .req(req_one),
        .other_busy(stat_two.busy), // RULE5
        .host_buffer_transfer(host_buffer_transfer),
        .periph_active(periph_active),
        .done(done_one),
        .status(stat_one)
    );

    // Axis two timer
    axis_start_timer #(
        .C_ZERO_MIN_P(C_ZERO_MIN_P),
        .C_INDEP_MIN_P(C_INDEP_MIN_P),
        .C_INTERP_MIN_P(C_INTERP_MIN_P),
        .C_ZERO_MAX_P(C_ZERO_MAX_P),
        .C_INDEP_MAX_P(C_INDEP_MAX_P),
        .C_INTERP_MAX_P(C_INTERP_MAX_P),
        .C_OTHER_P(C_OTHER_P),
        .C_PERIPH_P(C_PERIPH_P),
        .C_POINT_P(C_POINT_P)
    ) timer_two (
        .mclk(mclk),
        .reset(reset),
        .req(req_two),
        .other_busy(stat_one.busy), // RULE5
        .host_buffer_transfer(host_buffer_transfer),
        .periph_active(periph_active),
        .done(done_two),
        .status(stat_two)
    );

    // Outputs straight from flip-flops inside the timers
    assign busy_axis_one = stat_one.busy;
    assign busy_axis_two = stat_two.busy;
    assign pulse_enable_one = stat_one.pulse_enable;
    assign pulse_enable_two = stat_two.pulse_enable;
    assign err_valid_one = stat_one.err_valid;
    assign err_valid_two = stat_two.err_valid;
    assign err_code_one = stat_one.err_code;
    assign err_code_two = stat_two.err_code;

    // Battery indications registered
    always_ff @(posedge mclk) begin
        if (reset) begin
            battery_led <= 1'b0;
            battery_error <= 1'b0;
        end else begin
            battery_led <= battery_low; // RULE1
            battery_error <= battery_low; // RULE1
        end
    end
endmodule

// file: verif/axis_seq_chk.sv
// Port checks for the sequencer
`timescale 1ns/10ps
module axis_seq_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Observed inputs
    input wire logic done_one,
    input wire logic host_buffer_transfer,
    input wire logic battery_low,
    // Observed outputs
    input wire logic busy_axis_one,
    input wire logic pulse_enable_one,
    input wire logic err_valid_one,
    input wire logic battery_led,
    input wire logic battery_error,
    input wire logic [7:0] err_code_one
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Battery, busy, pulse and reject relations
    a_lamp_flag: assert property (battery_led == battery_error)
        else $error("lamp");
    a_lamp_rise: assert property ($rose(battery_low) |=> battery_led)
        else $error("lamp late");
    a_pulse_late: assert property (
        $rose(busy_axis_one) |=> pulse_enable_one) else $error("pulse");
    a_pulse_early: assert property (
        pulse_enable_one |-> $past(busy_axis_one)) else $error("pulse");
    a_busy_frozen: assert property (
        $rose(busy_axis_one) |-> !$past(host_buffer_transfer))
        else $error("hold");
    a_busy_hold: assert property (
        busy_axis_one && !done_one |=> busy_axis_one) else $error("busy");
    a_reject_code: assert property (
        err_valid_one |-> err_code_one == 8'h49) else $error("code");
    a_reject_pulse: assert property (
        err_valid_one |=> !err_valid_one) else $error("reject");
endmodule
bind axis_start_busy_sequencer axis_seq_chk seq_chk (.mclk, .reset, .done_one,
    .host_buffer_transfer, .battery_low, .busy_axis_one, .pulse_enable_one,
    .err_valid_one, .battery_led, .battery_error, .err_code_one);

// file: verif/cpu_model.sv
// Controller model: start levels and buffer transfers
`timescale 1ns/10ps
module cpu_model (
    // Clock in, requests out
    input wire logic mclk,
    output axis_seq_pkg::start_req_t req = '0,
    output logic host_buffer_transfer = 1'b0
);
    import axis_seq_pkg::*;
    // Drop start, then raise it with new fields
    task automatic start(op_kind_t op, logic cn, logic [4:0] pts);
        @(negedge mclk);
        req.start <= 1'b0;
        @(negedge mclk);
        req <= '{1'b1, op, cn, pts};
    endtask
    // Transfer of n cycles, a few cycles after a start
    task automatic transfer(int n);
        repeat (5) @(negedge mclk);
        host_buffer_transfer <= n > 0;
        repeat (n) @(negedge mclk);
        host_buffer_transfer <= 1'b0;
    endtask
endmodule

// file: verif/axis_start_busy_sequencer_test.sv
// Bench for the start-to-busy sequencer
`timescale 1ns/10ps
module axis_start_busy_sequencer_test;
    import axis_seq_pkg::*;
    // Short cycle counts: zero, independent, interpolation minima and
    // maxima, then other axis, peripheral and per speed-change point
    localparam int B[9] = '{10, 20, 30, 40, 50, 60, 15, 7, 5};
    localparam int LIMIT = 900;
    logic mclk = 1'b0, reset = 1'b1, periph_active = 1'b0;
    logic done_one = 1'b0, done_two = 1'b0, battery_low = 1'b0;
    logic host_buffer_transfer;
    logic busy_axis_one, busy_axis_two, pulse_enable_one, pulse_enable_two;
    logic err_valid_one, err_valid_two, battery_led, battery_error;
    logic [7:0] err_code_one, err_code_two;
    start_req_t req_one, req_two;
    int n_mismatch = 0, comparisons = 0;
    // Clock, one controller model per axis and the sequencer
    always #2.5 mclk = ~mclk;
    cpu_model cpu_one (.mclk, .req(req_one), .host_buffer_transfer);
    cpu_model cpu_two (.mclk, .req(req_two), .host_buffer_transfer());
    axis_start_busy_sequencer #(.C_ZERO_MIN_P(B[0]), .C_INDEP_MIN_P(B[1]),
        .C_INTERP_MIN_P(B[2]), .C_ZERO_MAX_P(B[3]), .C_INDEP_MAX_P(B[4]),
        .C_INTERP_MAX_P(B[5]), .C_OTHER_P(B[6]), .C_PERIPH_P(B[7]),
        .C_POINT_P(B[8])) uut (.*);
    // Compare of levels and codes
    task automatic chk_level(logic [15:0] got, logic [15:0] exp, string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    // Compare of cycle counts
    task automatic chk_cycles(int got, int exp, string what);
        comparisons++;
        if (got != exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %0d", $time, what, got);
        end
    endtask
    // Counts and verdict
    task automatic final_report;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Falling edges until busy of one axis shows; a timeout ends the run
    task automatic wait_busy(input logic two, output int k);
        for (k = 0; (two ? busy_axis_two : busy_axis_one) !== 1'b1
            && k < LIMIT; k++) @(negedge mclk);
        if (k == LIMIT) begin
            n_mismatch++;
            $display("MISMATCH %0t busy timeout", $time);
            final_report;
        end
    endtask
    // Axis one: start, latency, pulse, reject while busy, end by done;
    // busy shows three falling edges beyond the count (start, load, expiry)
    task automatic run_one(op_kind_t op, logic cn, logic pa, logic [4:0] pts,
        int h, int e);
        int k;
        periph_active = pa;
        cpu_one.start(op, cn, pts);
        if (h > 0) begin
            fork
                cpu_one.transfer(h);
            join_none
        end
        wait_busy(1'b0, k);
        chk_cycles(k, e, "latency");
        @(negedge mclk);
        chk_level(16'(pulse_enable_one), 16'h1, "pulse");
        cpu_one.start(op, cn, pts);
        @(negedge mclk);
        chk_level(16'({err_valid_one, err_code_one}),
            16'({1'b1, ERR_START_BUSY}), "reject");
        done_one = 1'b1;
        @(negedge mclk);
        chk_level(16'({busy_axis_one, pulse_enable_one, err_valid_one}),
            16'h0, "done");
        done_one = 1'b0;
    endtask
    // Outputs quiet after reset; lamp and flag follow the battery
    task automatic scen_reset_battery;
        @(negedge mclk);
        chk_level({busy_axis_one, busy_axis_two, pulse_enable_one,
            pulse_enable_two, err_valid_one, err_valid_two, battery_led,
            battery_error, err_code_one | err_code_two}, 16'h0,
            "reset");
        battery_low = 1'b1;
        repeat (2) @(negedge mclk);
        chk_level(16'({battery_led, battery_error}), 16'h3, "lamp");
        battery_low = 1'b0;
        repeat (2) @(negedge mclk);
        chk_level(16'({battery_led, battery_error}), 16'h0, "dark");
    endtask
    // Least latency after completed operations
    task automatic scen_min_latency;
        run_one(OP_ZERO, 1'b0, 1'b0, 5'h0, 0, B[0] + 3);
        run_one(OP_INDEP, 1'b0, 1'b0, 5'h0, 0, B[1] + 3);
        run_one(OP_INTERP, 1'b0, 1'b0, 5'h0, 0, B[2] + 3);
    endtask
    // Greatest latency after cancelled operations
    task automatic scen_max_latency;
        run_one(OP_ZERO, 1'b1, 1'b0, 5'h0, 0, B[3] + 3);
        run_one(OP_INDEP, 1'b1, 1'b0, 5'h0, 0, B[4] + 3);
        run_one(OP_INTERP, 1'b1, 1'b0, 5'h0, 0, B[5] + 3);
    endtask
    // Nine transfer cycles, a peripheral and three speed points add up
    task automatic scen_contention;
        run_one(OP_INDEP, 1'b0, 1'b1, 5'h3, 9,
            B[1] + B[7] + 3 * B[8] + 9 + 3);
        periph_active = 1'b0;
    endtask
    // Axis one started alone waits for no other-axis delay; axis two
    // started while axis one runs waits for it
    task automatic scen_other_axis;
        int k;
        cpu_one.start(OP_ZERO, 1'b0, 5'h0);
        wait_busy(1'b0, k);
        chk_cycles(k, B[0] + 3, "alone");
        cpu_two.start(OP_ZERO, 1'b0, 5'h0);
        wait_busy(1'b1, k);
        chk_cycles(k, B[0] + B[6] + 3, "other");
        @(negedge mclk);
        chk_level(16'({busy_axis_one, pulse_enable_two}), 16'h3,
            "pulse two");
        cpu_two.start(OP_ZERO, 1'b0, 5'h0);
        @(negedge mclk);
        chk_level(16'({err_valid_one, err_valid_two, err_code_two}),
            16'({2'b01, ERR_START_BUSY}), "reject two");
        done_one = 1'b1;
        done_two = 1'b1;
        @(negedge mclk);
        chk_level(16'({busy_axis_one, busy_axis_two, pulse_enable_one,
            pulse_enable_two, err_valid_two}), 16'h0, "done two");
        done_one = 1'b0;
        done_two = 1'b0;
    endtask
    // Reset for eight cycles, then the scenarios and the verdict
    initial begin
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        scen_reset_battery();
        scen_min_latency();
        scen_max_latency();
        scen_contention();
        scen_other_axis();
        final_report;
    end
endmodule
